/* rtl/pcl_device.sv */
// Chosen here: register access over APB.
`timescale 1ns/10ps
// Operation
// [R1] both groups locked after every restart
// [R2] locked group ignores register writes
// [R3] 0xdd to control lock unlocks control
// [R4] 0xaa to config lock unlocks configuration
// [R5] unlocked writes take effect at once
// [R6] fault reset restores all defaults
// [R7] nvm written only on burn command
// [R8] 0x2d at 0x4a starts nvm burn
// [R9] pin function 2 disables config crc
// [R10] host turns regulators off before changes
// [R11] rails gated by sequence and gpio inputs
// [R12] locked writes acknowledged, value unchanged
module pcl_device
    import pcl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    pcl_link_if.dev link,
    input wire logic fault_reset,
    input wire logic sequence_input,
    input wire logic gpio_input,
    output logic [N_RAIL-1:0] rail_on,
    output logic reset_out_on,
    output logic crc_error,
    output logic nvm_busy
);
    typedef enum logic [1:0] {PCL_IDLE, PCL_PROG, PCL_NEXT} pcl_burn_e;

    logic ctrl_locked;
    logic cfg_locked;
    logic [7:0] regulator_enable_register;
    logic [7:0] pin_func;
    logic [7:0] cfg [CFG_N];
    logic [7:0] nvm [NVM_N];
    logic [7:0] nvm_image;
    logic [7:0] rd_mux;
    logic wr_go;
    logic burn_start;
    logic burn_done;
    pcl_burn_e state;
    logic [7:0] burn_idx;
    logic [7:0] burn_cnt;
    logic [7:0] cfg_dflt_sum;

    // decoded write strobe, one per taken request
    assign wr_go = link.req && link.wr && !link.ack;
    assign burn_start = wr_go && link.addr == A_NVM_BURN && link.wdata == BURN_CMD; // [R8]
    assign cfg_dflt_sum = cfg_sum(RST_CFG);

    // link handshake: answer one cycle after the request shows
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            link.ack <= 1'b0;
        else
            link.ack <= link.req && !link.ack; // [R12]
    end

    // lock state, relocked by restart, fault or a non-key write to its own lock address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_locked <= 1'b1; // [R1]
            cfg_locked <= 1'b1; // [R1]
        end
        else if (fault_reset)
        begin
            ctrl_locked <= 1'b1; // [R6]
            cfg_locked <= 1'b1;
        end
        else if (wr_go)
        begin
            if (link.addr == A_CTRL_LOCK)
                ctrl_locked <= link.wdata != KEY_CTRL; // [R3]
            if (link.addr == A_CFG_LOCK)
                cfg_locked <= link.wdata != KEY_CFG; // [R4]
        end
    end

    // control group: regulator enables and pin function
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            regulator_enable_register <= RST_REG_EN;
            pin_func <= RST_PIN_FUNC;
        end
        else if (fault_reset)
        begin
            regulator_enable_register <= RST_REG_EN; // [R6]
            pin_func <= RST_PIN_FUNC;
        end
        else if (wr_go && !ctrl_locked) // [R2] [R12]
        begin
            if (link.addr == A_REG_EN)
                regulator_enable_register <= link.wdata; // [R5] [R10]
            if (link.addr == A_PIN_FUNC)
                pin_func <= link.wdata; // [R9]
        end
    end

    // configuration group, one byte per address
    generate
        for (genvar g = 0; g < CFG_N; g++)
        begin : g_cfg
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cfg[g] <= RST_CFG[g];
                else if (fault_reset)
                    cfg[g] <= RST_CFG[g]; // [R6]
                else if (wr_go && !cfg_locked && link.addr == A_CFG_BASE + 8'(g)) // [R2]
                    cfg[g] <= link.wdata; // [R5]
            end
        end
    endgenerate

    // rail gating from the trigger bytes, applied live
    generate
        for (genvar r = 0; r < N_RAIL; r++)
        begin : g_rail
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    rail_on[r] <= 1'b0;
                else
                    rail_on[r] <= regulator_enable_register[r]
                        && (cfg[r][TRIG_MASK_SEQ] || sequence_input) // [R11]
                        && (cfg[r][TRIG_MASK_GPIO] || gpio_input); // [R11]
            end
        end
    endgenerate

    // reset output follows its enable bit and the sequence input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reset_out_on <= 1'b0;
        else
            reset_out_on <= regulator_enable_register[N_RAIL] && sequence_input; // [R11]
    end

    // configuration check against the default checksum unless disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            crc_error <= 1'b0;
        else
            crc_error <= pin_func != PIN_FUNC_CRC_OFF && cfg_sum(cfg) != cfg_dflt_sum; // [R9]
    end

    // byte of the live image that the burn walk is copying
    always_comb
    begin
        if (burn_idx == 8'h00)
            nvm_image = regulator_enable_register;
        else if (burn_idx == 8'h01)
            nvm_image = pin_func;
        else
            nvm_image = cfg[3'(burn_idx[3:0] - 4'h2)];
    end

    // burn sequencer: one byte per programming time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= PCL_IDLE;
            burn_idx <= 8'h00;
            burn_cnt <= 8'h00;
        end
        else
        begin
            unique case (state)
                PCL_IDLE:
                begin
                    burn_idx <= 8'h00;
                    burn_cnt <= 8'h00;
                    if (burn_start)
                        state <= PCL_PROG; // [R7] [R8]
                end
                PCL_PROG:
                begin
                    if (fault_reset)
                        state <= PCL_IDLE;
                    else if (burn_cnt == 8'(NVM_BYTE_CYC - 1))
                        state <= PCL_NEXT;
                    else
                        burn_cnt <= burn_cnt + 8'h01;
                end
                PCL_NEXT:
                begin
                    burn_cnt <= 8'h00;
                    if (fault_reset || burn_idx == 8'(NVM_N - 1))
                        state <= PCL_IDLE;
                    else
                    begin
                        burn_idx <= burn_idx + 8'h01;
                        state <= PCL_PROG;
                    end
                end
            endcase
        end
    end

    assign burn_done = state == PCL_NEXT;

    // nonvolatile store: no reset, written only by the burn walk
    always_ff @(posedge pclk)
    begin
        if (burn_done)
            nvm[burn_idx[3:0]] <= nvm_image; // [R7]
    end

    // busy flag seen by the pins and the status register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nvm_busy <= 1'b0;
        else
            nvm_busy <= state != PCL_IDLE || burn_start;
    end

    // read decode, unmapped addresses read zero
    always_comb
    begin
        rd_mux = 8'h00;
        if (link.addr == A_CTRL_LOCK)
            rd_mux = ctrl_locked ? LOCKED_RD : UNLOCKED_RD;
        else if (link.addr == A_CFG_LOCK)
            rd_mux = cfg_locked ? LOCKED_RD : UNLOCKED_RD;
        else if (link.addr == A_REG_EN)
            rd_mux = regulator_enable_register;
        else if (link.addr == A_PIN_FUNC)
            rd_mux = pin_func;
        else if (link.addr == A_NVM_STAT)
            rd_mux = {7'h00, nvm_busy};
        else if (link.addr >= A_CFG_BASE && link.addr < A_CFG_BASE + 8'(CFG_N))
            rd_mux = cfg[3'(link.addr - A_CFG_BASE)];
        else if (link.addr >= A_NVM_BASE && link.addr < A_NVM_BASE + 8'(NVM_N))
            rd_mux = nvm[4'(link.addr - A_NVM_BASE)];
    end

    // read data captured with the answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            link.rdata <= 8'h00;
        else if (link.req && !link.ack && !link.wr)
            link.rdata <= rd_mux;
    end
endmodule // pcl_device

/* rtl/pcl_pkg.sv */
package pcl_pkg;
    // link widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // device register addresses
    localparam logic [7:0] A_CTRL_LOCK = 8'h01;
    localparam logic [7:0] A_REG_EN = 8'h02;
    localparam logic [7:0] A_PIN_FUNC = 8'h03;
    localparam logic [7:0] A_CFG_LOCK = 8'h04;
    localparam logic [7:0] A_CFG_BASE = 8'h05;
    localparam logic [7:0] A_NVM_BURN = 8'h4a;
    localparam logic [7:0] A_NVM_STAT = 8'h4b;
    localparam logic [7:0] A_NVM_BASE = 8'h50;
    localparam int CFG_N = 8;
    localparam int NVM_N = 2 + CFG_N;

    // key and command values
    localparam logic [7:0] KEY_CTRL = 8'hdd;
    localparam logic [7:0] KEY_CFG = 8'haa;
    localparam logic [7:0] BURN_CMD = 8'h2d;
    localparam logic [7:0] PIN_FUNC_CRC_OFF = 8'h02;

    // factory defaults
    localparam logic [7:0] RST_REG_EN = 8'h1f;
    localparam logic [7:0] RST_PIN_FUNC = 8'h00;
    localparam logic [7:0] RST_CFG [CFG_N] = '{8'h02, 8'h00, 8'h03, 8'h02,
                                              8'h10, 8'h1d, 8'h0a, 8'h0e};
    localparam logic [7:0] LOCKED_RD = 8'h01;
    localparam logic [7:0] UNLOCKED_RD = 8'h00;

    // regulator gating: trigger byte bits mask an input out of the gate
    localparam int N_RAIL = 4;
    localparam int TRIG_MASK_SEQ = 0;
    localparam int TRIG_MASK_GPIO = 1;

    // nvm programming time per byte
    localparam int CLK_NS = 4;
    localparam int NVM_BYTE_NS = 100;
    localparam int NVM_BYTE_CYC = (NVM_BYTE_NS + CLK_NS - 1) / CLK_NS;

    // controller apb map and fields
    localparam logic [11:0] H_CMD = 12'h000;
    localparam logic [11:0] H_STAT = 12'h004;
    localparam logic [11:0] H_IRQ_ST = 12'h008;
    localparam logic [11:0] H_IRQ_MASK = 12'h00c;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_WR_BIT = 16;
    localparam int STAT_RD_LSB = 8;
    localparam int IRQ_N = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVERRUN = 1;

    // xor checksum over the configuration bytes
    function automatic logic [7:0] cfg_sum(input logic [7:0] v [CFG_N]);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < CFG_N; i++) s = s ^ v[i];
        return s;
    endfunction
endpackage

/* rtl/pcl_link_if.sv */
`timescale 1ns/10ps
interface pcl_link_if;
    import pcl_pkg::*;
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ack;
    logic [DATA_W-1:0] rdata;

    modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
    modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface

/* rtl/pcl_host.sv */
`timescale 1ns/10ps
module pcl_host
    import pcl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    pcl_link_if.host link
);
    logic busy;
    logic [7:0] last_rd;
    logic [IRQ_N-1:0] irq_st;
    logic [IRQ_N-1:0] irq_mask;
    logic [IRQ_N-1:0] ev;
    logic apb_wr;
    logic cmd_go;
    logic [31:0] rd_word;

    // apb answers in the access cycle without wait states
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign apb_wr = psel && penable && pwrite;
    assign cmd_go = apb_wr && paddr == H_CMD;
    assign ev[IRQ_DONE] = link.req && link.ack;
    assign ev[IRQ_OVERRUN] = cmd_go && busy;
    assign irq = |(irq_st & irq_mask);

    // link request held until the device answers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link.req <= 1'b0;
            link.wr <= 1'b0;
            link.addr <= 8'h00;
            link.wdata <= 8'h00;
            busy <= 1'b0;
        end
        else if (cmd_go && !busy)
        begin
            link.req <= 1'b1; // [R3] [R4] [R8] [R9] [R10]
            link.wr <= pwdata[CMD_WR_BIT];
            link.addr <= pwdata[CMD_ADDR_LSB +: ADDR_W];
            link.wdata <= pwdata[DATA_W-1:0];
            busy <= 1'b1;
        end
        else if (link.req && link.ack)
        begin
            link.req <= 1'b0;
            busy <= 1'b0;
        end
    end

    // read data of the last read transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_rd <= 8'h00;
        else if (link.req && link.ack && !link.wr)
            last_rd <= link.rdata;
    end

    // sticky status, set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_st <= '0;
        else if (apb_wr && paddr == H_IRQ_ST)
            irq_st <= (irq_st & ~pwdata[IRQ_N-1:0]) | ev;
        else
            irq_st <= irq_st | ev;
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= '0;
        else if (apb_wr && paddr == H_IRQ_MASK)
            irq_mask <= pwdata[IRQ_N-1:0];
    end

    // apb read decode, unmapped reads zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (paddr == H_CMD)
            rd_word = {15'h0, link.wr, link.addr, link.wdata};
        else if (paddr == H_STAT)
            rd_word = {16'h0000, last_rd, 7'h00, busy};
        else if (paddr == H_IRQ_ST)
            rd_word = {30'h0, irq_st};
        else if (paddr == H_IRQ_MASK)
            rd_word = {30'h0, irq_mask};
    end

    // read word latched in the setup cycle, stands through the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= rd_word;
    end
endmodule // pcl_host

/* tb/pcl_link_monitor.sv */
`timescale 1ns/10ps
module pcl_link_monitor
    import pcl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic wr,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic ack,
    input wire logic [DATA_W-1:0] rdata
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // handshake timing on the link
    a_ack_after_req: assert property (req && !ack |=> ack)
        else $error("request not answered in one cycle");
    a_ack_one_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_no_stray_ack: assert property (!req |=> !ack)
        else $error("ack without request");
    a_req_drops: assert property (ack |=> !req)
        else $error("request held after ack");
    a_req_held: assert property (req && !ack |=> req && $stable(wr) && $stable(addr)
        && $stable(wdata))
        else $error("request changed before ack");
    // read data and readback codes
    a_rdata_hold: assert property ($changed(rdata) |-> ack && !wr)
        else $error("read byte changed outside a read");
    a_burn_reads_zero: assert property (ack && !wr && addr == A_NVM_BURN |-> rdata == 8'h00)
        else $error("burn command register not write-only");
    a_lock_code: assert property (ack && !wr && (addr == A_CTRL_LOCK || addr == A_CFG_LOCK)
        |-> rdata == LOCKED_RD || rdata == UNLOCKED_RD)
        else $error("bad lock readback");
endmodule // pcl_link_monitor

/* tb/tb_pmic_config_lock_nvm_program.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_pmic_config_lock_nvm_program;
    import pcl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_q;
    logic pready, pslverr, irq, fault_reset = 0, sequence_input = 0, gpio_input = 0;
    logic [N_RAIL-1:0] rail_on;
    logic reset_out_on, crc_error, nvm_busy;
    logic [7:0] reg_sh, pin_sh, b, t;
    logic [7:0] cfg_sh [CFG_N];
    int miscompares = 0, n_tests = 0, r;
    pcl_link_if link ();
    pcl_device u_pcl_device (.pclk(pclk), .presetn(presetn), .link(link),
        .fault_reset(fault_reset), .sequence_input(sequence_input), .gpio_input(gpio_input),
        .rail_on(rail_on), .reset_out_on(reset_out_on), .crc_error(crc_error),
        .nvm_busy(nvm_busy));
    pcl_host u_pcl_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    pcl_link_monitor u_pcl_link_monitor (.pclk(pclk), .presetn(presetn), .req(link.req),
        .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
        .rdata(link.rdata));

    // clock and read word capture at the sampling edge
    always #2 pclk = ~pclk;
    always @(posedge pclk) rd_q <= prdata;

    // expected rail, checksum flag and nvm image byte
    function automatic logic rail_exp(int i);
        return reg_sh[i] & (cfg_sh[i][TRIG_MASK_SEQ] | sequence_input)
            & (cfg_sh[i][TRIG_MASK_GPIO] | gpio_input);
    endfunction
    function automatic logic crc_exp();
        logic [7:0] x;
        x = 8'h00;
        for (int i = 0; i < CFG_N; i++)
            x = x ^ cfg_sh[i] ^ RST_CFG[i];
        return pin_sh != PIN_FUNC_CRC_OFF && x != 8'h00;
    endfunction
    function automatic logic [7:0] nvm_exp(int i);
        if (i == 0)
            return reg_sh;
        if (i == 1)
            return pin_sh;
        return cfg_sh[i - 2];
    endfunction

    // setup and access phases, returns at the edge that takes the transfer
    task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
    endtask
    // one apb transfer, read word left in rd_q
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        apb_xfer(w, a, d);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    // device access through the controller, waits until idle
    task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, H_CMD, {15'h0, w, a, d});
        do
            apb(1'b0, H_STAT, 32'h0);
        while (rd_q[0] !== 1'b0);
        b = rd_q[15:8];
    endtask
    task automatic unlock();
        dev(1, A_CTRL_LOCK, KEY_CTRL);
        dev(1, A_CFG_LOCK, KEY_CFG);
        dev(0, A_CTRL_LOCK, 0);
        `CHK("ctrl open", UNLOCKED_RD, b)
        dev(0, A_CFG_LOCK, 0);
        `CHK("cfg open", UNLOCKED_RD, b)
    endtask
    task automatic complete_run();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        complete_run();
    end

    // main sequence
    initial
    begin
        void'($urandom(9339));
        reg_sh = RST_REG_EN;
        pin_sh = RST_PIN_FUNC;
        cfg_sh = RST_CFG;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        dev(0, A_CFG_LOCK, 0);
        `CHK("cfg lock", LOCKED_RD, b)
        dev(1, A_REG_EN, 8'h05);
        dev(1, A_CFG_BASE, 8'h01);
        dev(0, A_REG_EN, 0);
        `CHK("locked reg", RST_REG_EN, b)
        dev(0, A_CFG_BASE, 0);
        `CHK("locked cfg", RST_CFG[0], b)
        unlock();
        dev(1, A_CTRL_LOCK, KEY_CFG);
        dev(0, A_CTRL_LOCK, 0);
        `CHK("wrong key", LOCKED_RD, b)
        unlock();
        // rails off first, then gating per trigger byte
        dev(1, A_REG_EN, 8'h00);
        `CHK("rails off", 4'h0, rail_on)
        dev(1, A_REG_EN, 8'h1f);
        reg_sh = 8'h1f;
        for (int i = 0; i < 12; i++)
        begin
            r = i % N_RAIL;
            t = 8'($urandom_range(0, 3));
            cfg_sh[r] = t;
            dev(1, A_CFG_BASE + 8'(r), t);
            @(posedge pclk);
            sequence_input <= 1'($urandom);
            gpio_input <= 1'($urandom);
            repeat (3) @(posedge pclk);
            `CHK("rail", rail_exp(r), rail_on[r])
            `CHK("rst out", sequence_input, reset_out_on)
            `CHK("crc", crc_exp(), crc_error)
        end
        cfg_sh[4] = 8'h55;
        dev(1, A_CFG_BASE + 8'h04, 8'h55);
        `CHK("crc on", crc_exp(), crc_error)
        dev(1, A_PIN_FUNC, PIN_FUNC_CRC_OFF);
        pin_sh = PIN_FUNC_CRC_OFF;
        repeat (2) @(posedge pclk);
        `CHK("crc off", 1'b0, crc_error)
        // only the burn command copies the live settings
        dev(1, A_NVM_BURN, 8'h2c);
        `CHK("no burn", 1'b0, nvm_busy)
        dev(1, A_NVM_BURN, BURN_CMD);
        `CHK("burn busy", 1'b1, nvm_busy)
        for (int k = 0; k < 400 && nvm_busy !== 1'b0; k++)
            @(posedge pclk);
        `CHK("burn end", 1'b0, nvm_busy)
        for (int i = 0; i < NVM_N; i++)
        begin
            dev(0, A_NVM_BASE + 8'(i), 0);
            `CHK("nvm", nvm_exp(i), b)
        end
        dev(1, A_REG_EN, 8'h0a);
        dev(0, A_NVM_BASE, 0);
        `CHK("nvm kept", 8'h1f, b)
        dev(0, A_NVM_BURN, 0);
        `CHK("burn reads", 8'h00, b)
        // fault restores defaults and locks
        @(posedge pclk);
        fault_reset <= 1'b1;
        repeat (3) @(posedge pclk);
        fault_reset <= 1'b0;
        dev(0, A_CTRL_LOCK, 0);
        `CHK("fault lock", LOCKED_RD, b)
        dev(0, A_REG_EN, 0);
        `CHK("fault reg", RST_REG_EN, b)
        dev(0, A_CFG_BASE + 8'h04, 0);
        `CHK("fault cfg", RST_CFG[4], b)
        // two command writes back to back: the second lands while busy
        @(posedge pclk);
        apb_xfer(1'b1, H_CMD, {15'h0, 1'b1, A_NVM_STAT, 8'h00});
        apb_xfer(1'b1, H_CMD, {15'h0, 1'b1, A_NVM_STAT, 8'h00});
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
        // interrupt: sticky done and overrun bits, mask, clear, unmapped read
        apb(0, H_IRQ_ST, 0);
        `CHK("done", 1'b1, rd_q[IRQ_DONE])
        `CHK("overrun", 1'b1, rd_q[IRQ_OVERRUN])
        `CHK("slverr", 1'b0, pslverr)
        `CHK("masked", 1'b0, irq)
        apb(1, H_IRQ_MASK, 32'h1);
        `CHK("irq", 1'b1, irq)
        apb(1, H_IRQ_ST, 32'h3);
        `CHK("irq clr", 1'b0, irq)
        apb(0, 12'h010, 0);
        `CHK("unmapped", 32'h0, rd_q)
        // second restart relocks
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        dev(0, A_CTRL_LOCK, 0);
        `CHK("relock", LOCKED_RD, b)
        complete_run();
    end
endmodule // tb_pmic_config_lock_nvm_program
